/* icap_top.sv */
// three channel input capture sharing one 16-bit time base
`timescale 1ns/10ps
`default_nettype none
`include "icap_params.svh"

module icap_top #(
	parameter int TB_WIDTH = `ICAP_TB_WIDTH
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CAP_IN_1,
	input wire logic CAP_IN_2,
	input wire logic CAP_IN_3,
	input wire logic CTRL_WR_1,
	input wire logic CTRL_WR_2,
	input wire logic CTRL_WR_3,
	input wire logic [7:0] CTRL_WR_DATA,
	output logic [7:0] CTRL_1,
	output logic [7:0] CTRL_2,
	output logic [7:0] CTRL_3,
	input wire logic QUADRATURE_DECODER_EN,
	input wire logic TIME_BASE_WR,
	input wire logic [TB_WIDTH-1:0] TIME_BASE_WR_DATA,
	input wire logic TIME_BASE_RUN_WR,
	input wire logic TIME_BASE_RUN_WR_DATA,
	input wire logic SPECIAL_RESET_EN,
	output logic [TB_WIDTH-1:0] SHARED_TIME_BASE,
	output logic TIME_BASE_RUN,
	output logic [TB_WIDTH-1:0] CAPTURE_BUFFER_1,
	output logic [TB_WIDTH-1:0] CAPTURE_BUFFER_2,
	output logic [TB_WIDTH-1:0] CAPTURE_BUFFER_3,
	output logic CHANNEL_ONE_CAPTURE_FLAG,
	output logic CHANNEL_TWO_CAPTURE_FLAG,
	output logic CHANNEL_THREE_CAPTURE_FLAG,
	input wire logic FLAG_CLR_1,
	input wire logic FLAG_CLR_2,
	input wire logic FLAG_CLR_3,
	output logic SPECIAL_TRIGGER,
	output logic [1:0] QUARTER_PHASE
);

	localparam int NCH = 3;

	if (TB_WIDTH != `ICAP_TB_WIDTH) begin : g_width_check
		$error("icap_top: time base width must be 16");
	end

	// the mode field must stay four bits wide and below the reset enable
	if (`ICAP_MODE_MSB - `ICAP_MODE_LSB != 3 ||
			`ICAP_REN_BIT <= `ICAP_MODE_MSB) begin : g_layout_check
		$error("icap_top: channel control layout is inconsistent");
	end

	// ************************************************************
	// quarter phase sequencer
	// ************************************************************
	icap_pkg::icap_phase_t phase_ff, nxt_phase;
	logic q1_edge;
	logic q2_edge;
	logic q4_edge;

	always_comb begin
		case (phase_ff)
		icap_pkg::ICAP_Q1: nxt_phase = icap_pkg::ICAP_Q2;
		icap_pkg::ICAP_Q2: nxt_phase = icap_pkg::ICAP_Q3;
		icap_pkg::ICAP_Q3: nxt_phase = icap_pkg::ICAP_Q4;
		icap_pkg::ICAP_Q4: nxt_phase = icap_pkg::ICAP_Q1;
		default: nxt_phase = icap_pkg::ICAP_Q1;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			phase_ff <= icap_pkg::ICAP_Q1;
		end else begin
			phase_ff <= nxt_phase;
		end
	end

	// an edge named after a phase is the clock edge that enters it
	assign q2_edge = (phase_ff == icap_pkg::ICAP_Q1);
	assign q4_edge = (phase_ff == icap_pkg::ICAP_Q3);
	assign q1_edge = (phase_ff == icap_pkg::ICAP_Q4);
	assign QUARTER_PHASE = phase_ff;

	// ************************************************************
	// channel control registers
	// ************************************************************
	logic [NCH-1:0] cap_in;
	logic [NCH-1:0] ctrl_wr;
	logic [NCH-1:0] flag_clr;
	logic [7:0] ctrl_ff [NCH];
	logic [7:0] nxt_ctrl [NCH];

	assign cap_in = {CAP_IN_3, CAP_IN_2, CAP_IN_1};
	assign ctrl_wr = {CTRL_WR_3, CTRL_WR_2, CTRL_WR_1};
	assign flag_clr = {FLAG_CLR_3, FLAG_CLR_2, FLAG_CLR_1};

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			nxt_ctrl[i] = ctrl_ff[i];
			if (ctrl_wr[i]) begin
				// unimplemented bits always read as zero
				nxt_ctrl[i] = CTRL_WR_DATA & `ICAP_CTRL_MASK;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < NCH; i++) begin
				ctrl_ff[i] <= `ICAP_CTRL_RST;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				ctrl_ff[i] <= nxt_ctrl[i];
			end
		end
	end

	assign CTRL_1 = ctrl_ff[0];
	assign CTRL_2 = ctrl_ff[1];
	assign CTRL_3 = ctrl_ff[2];

	// ************************************************************
	// channels
	// ************************************************************
	logic [NCH-1:0] cap_evt;
	logic [NCH-1:0] rst_evt;
	logic [NCH-1:0] trig_evt;
	logic capture_enable;

	// the decoder owns the shared pins whenever it is on
	assign capture_enable = ~QUADRATURE_DECODER_EN;

	for (genvar g = 0; g < NCH; g++) begin : g_chan
		icap_chan #(
			.HAS_TRIGGER(g == 0)
		) u_chan (
			.clk(CLK),
			.rst_n(RST_N),
			.q2_edge(q2_edge),
			.q4_edge(q4_edge),
			.q1_edge(q1_edge),
			.cap_in(cap_in[g]),
			.mode(ctrl_ff[g][`ICAP_MODE_MSB:`ICAP_MODE_LSB]),
			.mode_wr(ctrl_wr[g]),
			.mode_wr_data(CTRL_WR_DATA[`ICAP_MODE_MSB:`ICAP_MODE_LSB]),
			.ren(ctrl_ff[g][`ICAP_REN_BIT]),
			.enable(capture_enable),
			.cap_evt(cap_evt[g]),
			.rst_evt(rst_evt[g]),
			.trig_evt(trig_evt[g])
		);
	end

	// ************************************************************
	// shared time base and run bit
	// ************************************************************
	logic [TB_WIDTH-1:0] tb_ff, nxt_tb;
	logic [TB_WIDTH-1:0] tb_inc;
	logic [TB_WIDTH-1:0] cap_val;
	logic run_ff, nxt_run;
	logic spec_reset;

	assign spec_reset = trig_evt[0] & SPECIAL_RESET_EN;
	assign tb_inc = run_ff ? tb_ff + 16'h0001 : tb_ff;
	// a coinciding write is what the buffers see as well
	assign cap_val = TIME_BASE_WR ? TIME_BASE_WR_DATA : tb_inc;

	always_comb begin
		nxt_tb = tb_ff;
		if (q1_edge) begin
			nxt_tb = tb_inc;
			// mode writes never reach the count
			if ((|rst_evt) || spec_reset) begin
				nxt_tb = `ICAP_TB_RST;
			end
		end
		if (TIME_BASE_WR) begin
			nxt_tb = TIME_BASE_WR_DATA;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			tb_ff <= `ICAP_TB_RST;
		end else begin
			tb_ff <= nxt_tb;
		end
	end

	assign SHARED_TIME_BASE = tb_ff;

	// ************************************************************
	// run bit and special trigger
	// ************************************************************
	logic trig_ff, nxt_trig;

	always_comb begin
		nxt_run = run_ff;
		if (TIME_BASE_RUN_WR) begin
			nxt_run = TIME_BASE_RUN_WR_DATA;
		end
		// with the special reset enabled, the trigger starts a stopped time base and beats a run write
		if (spec_reset) begin
			nxt_run = 1'b1;
		end
		// one-cycle pulse, so a level-sensitive consumer sees one event
		nxt_trig = trig_evt[0];
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			run_ff <= 1'b0;
			trig_ff <= 1'b0;
		end else begin
			run_ff <= nxt_run;
			trig_ff <= nxt_trig;
		end
	end

	assign TIME_BASE_RUN = run_ff;
	assign SPECIAL_TRIGGER = trig_ff;

	// ************************************************************
	// capture buffers and flags
	// ************************************************************
	logic [TB_WIDTH-1:0] buf_ff [NCH];
	logic [TB_WIDTH-1:0] nxt_buf [NCH];
	logic [NCH-1:0] flag_ff, nxt_flag;

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			nxt_buf[i] = buf_ff[i];
			if (cap_evt[i]) begin
				nxt_buf[i] = cap_val;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < NCH; i++) begin
				buf_ff[i] <= `ICAP_TB_RST;
			end
		end else begin
			for (int i = 0; i < NCH; i++) begin
				buf_ff[i] <= nxt_buf[i];
			end
		end
	end

	// flags are sticky until cleared; trigger events never reach them
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			nxt_flag[i] = flag_ff[i] & ~flag_clr[i];
			// a capture in the clearing cycle keeps the flag
			if (cap_evt[i]) begin
				nxt_flag[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			flag_ff <= 3'h0;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	assign CAPTURE_BUFFER_1 = buf_ff[0];
	assign CAPTURE_BUFFER_2 = buf_ff[1];
	assign CAPTURE_BUFFER_3 = buf_ff[2];
	assign CHANNEL_ONE_CAPTURE_FLAG = flag_ff[0];
	assign CHANNEL_TWO_CAPTURE_FLAG = flag_ff[1];
	assign CHANNEL_THREE_CAPTURE_FLAG = flag_ff[2];

endmodule
`default_nettype wire

/* icap_params.svh */
// constants for the three channel input capture block
`ifndef ICAP_PARAMS_SVH
`define ICAP_PARAMS_SVH

// capture mode select codes
`define ICAP_MODE_OFF 4'h0
`define ICAP_MODE_FALL 4'h1
`define ICAP_MODE_RISE 4'h2
`define ICAP_MODE_RISE4 4'h3
`define ICAP_MODE_RISE16 4'h4
`define ICAP_MODE_PERIOD 4'h5
`define ICAP_MODE_PW_FR 4'h6
`define ICAP_MODE_PW_RF 4'h7
`define ICAP_MODE_CHANGE 4'h8
`define ICAP_MODE_TRIG_FALL 4'hE
`define ICAP_MODE_TRIG_RISE 4'hF

// channel control layout
`define ICAP_REN_BIT 6
`define ICAP_MODE_MSB 3
`define ICAP_MODE_LSB 0
`define ICAP_CTRL_MASK 8'h4F
`define ICAP_CTRL_RST 8'h00

// prescaler terminal counts (count of rising edges minus one)
`define ICAP_PRESC_DIV4 4'h3
`define ICAP_PRESC_DIV16 4'hF
`define ICAP_PRESC_RST 4'h0

// time base
`define ICAP_TB_RST 16'h0000
`define ICAP_TB_WIDTH 16

`endif

/* icap_pkg.sv */
// types shared by the input capture block
package icap_pkg;

	// quarter phases of one instruction cycle
	typedef enum logic [1:0] {
		ICAP_Q1,
		ICAP_Q2,
		ICAP_Q3,
		ICAP_Q4
	} icap_phase_t;

	// pulse width measurement progress
	typedef enum logic {
		ICAP_PW_START,
		ICAP_PW_CLOSE
	} icap_pw_t;

endpackage

/* icap_chan.sv */
// one capture channel: edge detection, prescaler and mode decode
`timescale 1ns/10ps
`default_nettype none
`include "icap_params.svh"

module icap_chan #(
	parameter bit HAS_TRIGGER = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic q2_edge,
	input wire logic q4_edge,
	input wire logic q1_edge,
	input wire logic cap_in,
	input wire logic [3:0] mode,
	input wire logic mode_wr,
	input wire logic [3:0] mode_wr_data,
	input wire logic ren,
	input wire logic enable,
	output logic cap_evt,
	output logic rst_evt,
	output logic trig_evt
);

	// ************************************************************
	// edge sampling
	// ************************************************************
	logic sync_ff, nxt_sync;
	logic lvl_ff, nxt_lvl;
	logic rise_ff, nxt_rise;
	logic fall_ff, nxt_fall;

	always_comb begin
		nxt_sync = sync_ff;
		nxt_lvl = lvl_ff;
		nxt_rise = rise_ff;
		nxt_fall = fall_ff;
		if (q2_edge) begin
			nxt_sync = cap_in;
		end
		if (q4_edge) begin
			// edge seen at the second phase is handed on at the fourth
			nxt_lvl = sync_ff;
			nxt_rise = sync_ff & ~lvl_ff;
			nxt_fall = ~sync_ff & lvl_ff;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_ff <= 1'b0;
			lvl_ff <= 1'b0;
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
		end else begin
			sync_ff <= nxt_sync;
			lvl_ff <= nxt_lvl;
			rise_ff <= nxt_rise;
			fall_ff <= nxt_fall;
		end
	end

	// ************************************************************
	// mode decode, prescaler and first-edge arming
	// ************************************************************
	logic [3:0] presc_ff, nxt_presc;
	logic armed_ff, nxt_armed;
	icap_pkg::icap_pw_t pw_ff, nxt_pw;
	logic hit;
	logic start;
	logic close;
	logic any_edge;

	always_comb begin
		nxt_presc = presc_ff;
		nxt_armed = armed_ff;
		nxt_pw = pw_ff;
		hit = 1'b0;
		start = 1'b0;
		close = 1'b0;
		rst_evt = 1'b0;
		trig_evt = 1'b0;
		any_edge = rise_ff | fall_ff;
		if (q1_edge && enable) begin
			case (mode)
			`ICAP_MODE_FALL: hit = fall_ff;
			`ICAP_MODE_RISE: hit = rise_ff;
			`ICAP_MODE_RISE4: begin
				if (rise_ff) begin
					// count is kept across direct mode changes; a write of off clears it
					nxt_presc = presc_ff + 4'h1;
					if (presc_ff >= `ICAP_PRESC_DIV4) begin
						nxt_presc = `ICAP_PRESC_RST;
						hit = 1'b1;
					end
					if (armed_ff) begin
						hit = 1'b1;
					end
				end
			end
			`ICAP_MODE_RISE16: begin
				if (rise_ff) begin
					nxt_presc = presc_ff + 4'h1;
					if (presc_ff == `ICAP_PRESC_DIV16) begin
						nxt_presc = `ICAP_PRESC_RST;
						hit = 1'b1;
					end
					if (armed_ff) begin
						hit = 1'b1;
					end
				end
			end
			`ICAP_MODE_PERIOD: hit = rise_ff;
			`ICAP_MODE_CHANGE: hit = any_edge;
			`ICAP_MODE_PW_FR, `ICAP_MODE_PW_RF: begin
				start = (mode == `ICAP_MODE_PW_FR) ? fall_ff : rise_ff;
				close = (mode == `ICAP_MODE_PW_FR) ? rise_ff : fall_ff;
				if (armed_ff && any_edge) begin
					// the first edge resets the count, so a measurement is open
					hit = 1'b1;
					nxt_pw = icap_pkg::ICAP_PW_CLOSE;
				end else if (start) begin
					nxt_pw = icap_pkg::ICAP_PW_CLOSE;
				end else if (close
						&& pw_ff == icap_pkg::ICAP_PW_CLOSE) begin
					// a close edge without an open measurement is ignored unless it is the first edge
					hit = 1'b1;
					nxt_pw = icap_pkg::ICAP_PW_START;
				end
			end
			`ICAP_MODE_TRIG_FALL: trig_evt = HAS_TRIGGER & fall_ff;
			`ICAP_MODE_TRIG_RISE: trig_evt = HAS_TRIGGER & rise_ff;
			default: hit = 1'b0;
			endcase
			if (mode == `ICAP_MODE_PW_FR || mode == `ICAP_MODE_PW_RF) begin
				// reset enable is ignored while measuring pulses
				rst_evt = (armed_ff && any_edge) || (!armed_ff && start);
			end else begin
				rst_evt = hit & ren;
			end
			if (hit) begin
				nxt_armed = 1'b0;
			end
		end
		if (mode_wr) begin
			nxt_armed = (mode_wr_data != `ICAP_MODE_OFF);
			nxt_pw = icap_pkg::ICAP_PW_START;
			if (mode_wr_data == `ICAP_MODE_OFF) begin
				nxt_presc = `ICAP_PRESC_RST;
			end
		end
		cap_evt = hit;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			presc_ff <= `ICAP_PRESC_RST;
			armed_ff <= 1'b0;
			pw_ff <= icap_pkg::ICAP_PW_START;
		end else begin
			presc_ff <= nxt_presc;
			armed_ff <= nxt_armed;
			pw_ff <= nxt_pw;
		end
	end

endmodule
`default_nettype wire

/* icap_chk.sv */
// concurrent checks on the input capture top ports
`timescale 1ns/10ps
`default_nettype none
module icap_chk #(
	parameter int TB_WIDTH = 16
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CTRL_WR_1,
	input wire logic [7:0] CTRL_WR_DATA,
	input wire logic [7:0] CTRL_1,
	input wire logic QUADRATURE_DECODER_EN,
	input wire logic TIME_BASE_WR,
	input wire logic [TB_WIDTH-1:0] TIME_BASE_WR_DATA,
	input wire logic SPECIAL_RESET_EN,
	input wire logic [TB_WIDTH-1:0] SHARED_TIME_BASE,
	input wire logic TIME_BASE_RUN,
	input wire logic [TB_WIDTH-1:0] CAPTURE_BUFFER_1,
	input wire logic CHANNEL_ONE_CAPTURE_FLAG,
	input wire logic CHANNEL_TWO_CAPTURE_FLAG,
	input wire logic SPECIAL_TRIGGER,
	input wire logic [1:0] QUARTER_PHASE
);
	// ****
	// properties
	// ****
	default clocking dc @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	ctrl_readback_a: assert property (CTRL_WR_1 |=>
		CTRL_1 == ($past(CTRL_WR_DATA) & 8'h4F)) else $error("bad readback");
	flag_phase_a: assert property ($rose(CHANNEL_ONE_CAPTURE_FLAG) |->
		QUARTER_PHASE == 2'h0) else $error("flag off phase");
	// the time base only moves at the first phase or on a direct write
	tb_phase_a: assert property (QUARTER_PHASE != 2'h0 &&
		!$past(TIME_BASE_WR) |-> $stable(SHARED_TIME_BASE))
		else $error("time base moved");
	buf_phase_a: assert property (QUARTER_PHASE != 2'h0 |->
		$stable(CAPTURE_BUFFER_1)) else $error("buffer moved");
	trig_pulse_a: assert property (SPECIAL_TRIGGER |=>
		!SPECIAL_TRIGGER) else $error("trigger too long");
	trig_flag_a: assert property (SPECIAL_TRIGGER |->
		!$rose(CHANNEL_ONE_CAPTURE_FLAG)) else $error("trigger set flag");
	trig_reset_a: assert property (SPECIAL_TRIGGER &&
		$past(SPECIAL_RESET_EN) && !$past(TIME_BASE_WR) |->
		SHARED_TIME_BASE == 16'h0000 && TIME_BASE_RUN)
		else $error("trigger reset missing");
	qdec_block_a: assert property (QUADRATURE_DECODER_EN[*5] |=>
		!$rose(CHANNEL_ONE_CAPTURE_FLAG) && !$rose(CHANNEL_TWO_CAPTURE_FLAG))
		else $error("capture while decoder on");
	tb_write_a: assert property (TIME_BASE_WR |=>
		SHARED_TIME_BASE == $past(TIME_BASE_WR_DATA))
		else $error("time base write lost");

	cover property ($rose(CHANNEL_ONE_CAPTURE_FLAG));
	cover property ($rose(CHANNEL_TWO_CAPTURE_FLAG));
	cover property (SPECIAL_TRIGGER);
endmodule

bind icap_top icap_chk #(.TB_WIDTH(TB_WIDTH)) i_chk (.CLK, .RST_N,
	.CTRL_WR_1, .CTRL_WR_DATA, .CTRL_1, .QUADRATURE_DECODER_EN,
	.TIME_BASE_WR, .TIME_BASE_WR_DATA, .SPECIAL_RESET_EN,
	.SHARED_TIME_BASE, .TIME_BASE_RUN, .CAPTURE_BUFFER_1,
	.CHANNEL_ONE_CAPTURE_FLAG, .CHANNEL_TWO_CAPTURE_FLAG,
	.SPECIAL_TRIGGER, .QUARTER_PHASE);
`default_nettype wire

/* icap_sensor.sv */
// behavioural model of the three sensor lines on the capture pins
`timescale 1ns/10ps
`default_nettype none
module icap_sensor (
	output logic [2:0] pin
);
	// ****
	// levels
	// ****
	// lines are push-pull and hold their level; the bench spaces moves
	// two instruction cycles apart since shorter pulses may be missed
	initial pin = 3'h0;

	task automatic set_pin(input int ch, input logic lvl);
		pin[ch] = lvl;
	endtask
endmodule
`default_nettype wire

/* icap_tb.sv */
// self-checking bench for the three channel input capture
`timescale 1ns/10ps
`default_nettype none
module tb;
	// ****
	// harness
	// ****
	logic clk = 1'b0;
	logic rst_n, qdec_en, tb_wr, run_wr, run_data, spec_en, st;
	logic [2:0] ctrl_wr, flag_clr;
	logic [7:0] ctrl_data;
	logic [15:0] tb_data;
	wire logic [2:0] pin, flg;
	wire logic [15:0] cb [3];
	wire logic [15:0] tbase;
	wire logic [7:0] ctl1, ctl2, ctl3;
	wire logic run, trig;
	wire logic [1:0] phase;
	int bad_count = 0, samples_checked = 0, trig_seen = 0, k;

	always #10 clk = ~clk;
	always @(posedge clk) if (trig === 1'b1) trig_seen <= trig_seen + 1;

	icap_sensor i_sen (.pin(pin));
	icap_top i_dut (.CLK(clk), .RST_N(rst_n), .CAP_IN_1(pin[0]),
		.CAP_IN_2(pin[1]), .CAP_IN_3(pin[2]), .CTRL_WR_1(ctrl_wr[0]),
		.CTRL_WR_2(ctrl_wr[1]), .CTRL_WR_3(ctrl_wr[2]),
		.CTRL_WR_DATA(ctrl_data), .CTRL_1(ctl1), .CTRL_2(ctl2),
		.CTRL_3(ctl3),
		.QUADRATURE_DECODER_EN(qdec_en), .TIME_BASE_WR(tb_wr),
		.TIME_BASE_WR_DATA(tb_data), .TIME_BASE_RUN_WR(run_wr),
		.TIME_BASE_RUN_WR_DATA(run_data), .SPECIAL_RESET_EN(spec_en),
		.SHARED_TIME_BASE(tbase), .TIME_BASE_RUN(run),
		.CAPTURE_BUFFER_1(cb[0]), .CAPTURE_BUFFER_2(cb[1]),
		.CAPTURE_BUFFER_3(cb[2]), .CHANNEL_ONE_CAPTURE_FLAG(flg[0]),
		.CHANNEL_TWO_CAPTURE_FLAG(flg[1]),
		.CHANNEL_THREE_CAPTURE_FLAG(flg[2]), .FLAG_CLR_1(flag_clr[0]),
		.FLAG_CLR_2(flag_clr[1]), .FLAG_CLR_3(flag_clr[2]),
		.SPECIAL_TRIGGER(trig), .QUARTER_PHASE(phase));

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("compared %0d, mismatched %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wr_ctrl(input int ch, input logic [7:0] d);
		ctrl_wr[ch] = 1'b1;
		ctrl_data = d;
		tick(1);
		ctrl_wr = 3'h0;
		// let one edge pass so a following write starts a fresh pulse
		tick(1);
	endtask

	task automatic set_tb(input logic [15:0] v, input logic r);
		tb_wr = 1'b1;
		tb_data = v;
		run_wr = 1'b1;
		run_data = r;
		tick(1);
		tb_wr = 1'b0;
		run_wr = 1'b0;
	endtask

	task automatic clr();
		flag_clr = 3'h7;
		tick(1);
		flag_clr = 3'h0;
	endtask

	// move a pin in the last phase so the capture lands five edges later;
	// wr puts a time base write on that same capture edge
	task automatic pin_move(input int ch, input logic lvl, input logic wr);
		int n;
		for (n = 0; n < 8 && phase !== 2'h3; n++)
			tick(1);
		if (n == 8) begin
			bad_count++;
			$display("unexpected at %0t: phase wait ran out", $time);
			end_of_test();
		end
		i_sen.set_pin(ch, lvl);
		tick(wr ? 4 : 6);
		if (wr) begin
			tb_wr = 1'b1;
			tb_data = 16'h0BEE;
			tick(1);
			tb_wr = 1'b0;
			tick(1);
		end
	endtask

	// ****
	// scenarios
	// ****
	initial begin
		{ctrl_wr, flag_clr, ctrl_data, tb_data} = '0;
		{qdec_en, tb_wr, run_wr, run_data, spec_en, st} = '0;
		rst_n = 1'b0;
		tick(12);
		rst_n = 1'b1;
		check(tbase, 16'h0000);
		check(flg, 16'h0000);
		wr_ctrl(0, 8'hFF);
		check(ctl1, 8'h4F);
		for (int m = 1; m <= 4; m++) begin
			st = (m == 1);
			wr_ctrl(0, 8'h00);
			i_sen.set_pin(0, st);
			tick(8);
			set_tb(16'h1234, 1'b0);
			wr_ctrl(0, {1'b0, m != 2, 2'h0, 4'(m)});
			check(tbase, 16'h1234);
			clr();
			pin_move(0, !st, 1'b0);
			check(cb[0], 16'h1234);
			check(flg[0], 1'b1);
			check(tbase, m != 2 ? 16'h0000 : 16'h1234);
			clr();
			pin_move(0, st, 1'b0);
			check(flg[0], 1'b0);
			for (k = 2; m > 2 && k <= (m == 3 ? 4 : 16); k++) begin
				pin_move(0, 1'b1, 1'b0);
				check(flg[0], k == (m == 3 ? 4 : 16));
				pin_move(0, 1'b0, 1'b0);
			end
		end
		// leave one count in the /16 prescaler, then change mode directly
		// (count kept) and through off (count cleared)
		pin_move(0, 1'b1, 1'b0);
		pin_move(0, 1'b0, 1'b0);
		for (int j = 0; j < 2; j++) begin
			if (j == 1) begin
				wr_ctrl(0, 8'h00);
			end
			wr_ctrl(0, 8'h43);
			for (k = 1; k <= 4; k++) begin
				clr();
				pin_move(0, 1'b1, 1'b0);
				check(flg[0], j == 1 ? (k == 1 || k == 4) : k[0]);
				pin_move(0, 1'b0, 1'b0);
			end
		end
		for (int m = 6; m <= 7; m++) begin
			st = (m == 6);
			wr_ctrl(0, 8'h00);
			i_sen.set_pin(0, st);
			tick(8);
			set_tb(16'h0100, 1'b1);
			wr_ctrl(0, 8'(m));
			clr();
			pin_move(0, !st, 1'b0);
			check(flg[0], 1'b1);
			check(tbase, 16'h0000);
			clr();
			pin_move(0, st, 1'b0);
			check(cb[0], 16'h0002);
			clr();
			pin_move(0, !st, 1'b0);
			check(flg[0], 1'b0);
			check(tbase, 16'h0000);
		end
		wr_ctrl(0, 8'h00);
		i_sen.set_pin(0, 1'b0);
		tick(8);
		set_tb(16'h0000, 1'b1);
		wr_ctrl(0, 8'h45);
		pin_move(0, 1'b1, 1'b0);
		pin_move(0, 1'b0, 1'b0);
		pin_move(0, 1'b1, 1'b0);
		check(cb[0], 16'h0004);
		check(tbase, 16'h0000);
		pin_move(0, 1'b0, 1'b0);
		pin_move(0, 1'b1, 1'b1);
		check(cb[0], 16'h0BEE);
		check(tbase, 16'h0BEE);
		for (int c = 1; c <= 2; c++) begin
			wr_ctrl(c, 8'h08);
			check(c == 1 ? ctl2 : ctl3, 8'h08);
			set_tb(16'h0ABC, 1'b0);
			clr();
			pin_move(c, 1'b1, 1'b0);
			check(cb[c], 16'h0ABC);
			check(tbase, 16'h0ABC);
			clr();
			pin_move(c, 1'b0, 1'b0);
			check(flg[c], 1'b1);
		end
		spec_en = 1'b1;
		for (int m = 14; m <= 15; m++) begin
			st = (m == 14);
			wr_ctrl(0, 8'h00);
			i_sen.set_pin(0, st);
			tick(8);
			set_tb(16'h0777, 1'b0);
			wr_ctrl(0, 8'(m));
			clr();
			pin_move(0, !st, 1'b0);
			check(tbase, 16'h0000);
			check(run, 1'b1);
			check(flg[0], 1'b0);
			check(cb[0], 16'h0BEE);
			pin_move(0, st, 1'b0);
		end
		check(16'(trig_seen), 16'h0002);
		qdec_en = 1'b1;
		wr_ctrl(0, 8'h00);
		wr_ctrl(0, 8'h02);
		clr();
		pin_move(0, 1'b1, 1'b0);
		pin_move(0, 1'b0, 1'b0);
		check(flg[0], 1'b0);
		end_of_test();
	end
endmodule
`default_nettype wire
